// [logic/sfsfe_consts.vh]
// constants for the serial flash spi front end
// assumes inclusion by the single design file sfsfe_top.v
`ifndef SFSFE_CONSTS_VH
`define SFSFE_CONSTS_VH
// opcodes
`define SFSFE_OP_WREN    8'h06
`define SFSFE_OP_WRDI    8'h04
`define SFSFE_OP_RDSR    8'h05
`define SFSFE_OP_WRSR    8'h01
`define SFSFE_OP_READ    8'h03
`define SFSFE_OP_FREAD   8'h0b
`define SFSFE_OP_DREAD   8'h3b
`define SFSFE_OP_PP      8'h02
`define SFSFE_OP_SE      8'h20
`define SFSFE_OP_BE32    8'h52
`define SFSFE_OP_BE64    8'hd8
`define SFSFE_OP_CE      8'hc7
`define SFSFE_OP_PD      8'hb9
`define SFSFE_OP_RPD     8'hab
// status bit positions
`define SFSFE_S_BUSY     0
`define SFSFE_S_WL       1
`define SFSFE_S_SZ_LO    2
`define SFSFE_S_SZ_HI    4
`define SFSFE_S_SIDE     5
`define SFSFE_S_RSVD     6
`define SFSFE_S_LOCK     7
`define SFSFE_STATUS_RST 8'h00
// timing: power-up write delay in us, busy time in ns
`define SFSFE_CLK_NS     40
`define SFSFE_PUW_US     10
`define SFSFE_BUSY_NS    4000
// byte counts inside a frame
`define SFSFE_ADDR_END   4'h4
`define SFSFE_DUMMY_END  4'h5
`endif

// [logic/sfsfe_top.v]
// serial flash spi front end: sampling, driving, pause, write protection
// and status word; runs on core_clk, all pins are asynchronous to it
//
// Overview of operation
// - sample data line on rising serial clock
// - modes 0 and 3, rising-edge sampling both
// - change driven bits on falling serial clock
// - dual read drives bidir line as output
// - other instructions keep bidir line input
// - pause starts on pause fall, clock low
// - pause ends on pause rise, clock low
// - while paused, output off, inputs ignored
// - pause keeps partial instruction state intact
// - write-type opcodes refused during power-up delay
// - start write-disabled; write enable needed first
// - write enable sets write latch S1
// - write latch cleared by reset, writes
// - power-down ignores all but release
// - busy S0 during writes; only status reads
// - size bits S4..S2 writable, default zero
// - block writes into protected array region
// - side bit: 0 top, 1 bottom
// - lock plus protect low refuses status writes
// - reserved S6 always reads zero
// - lock bit with protect pin gates status writes
// - select fall starts, opcode msb first
// - writes need whole bytes; reads any bit
`timescale 1ns/1ps
`include "sfsfe_consts.vh"

module sfsfe_top #(
   parameter PUW_CYCLES  = (`SFSFE_PUW_US * 1000) / `SFSFE_CLK_NS,
   parameter BUSY_CYCLES = (`SFSFE_BUSY_NS + `SFSFE_CLK_NS - 1)
                           / `SFSFE_CLK_NS
) (
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire        sclk,
   input  wire        cs_n,
   input  wire        hold_n,
   input  wire        wp_n,
   input  wire        bidir_data_line_in,
   output reg         bidir_data_line_out,
   output reg         bidir_data_line_oe,
   output reg         dout,
   output reg         dout_oe,
   output reg         prog_strobe,
   output reg  [7:0]  prog_opcode,
   output reg  [23:0] prog_addr,
   output reg  [7:0]  status_view
);

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   reg [4:0] sync1;
   reg [4:0] sync2;
   reg       sclk_d;
   reg       cs_d;

   // two flops per pin; only stage two is looked at
   always @(posedge core_clk) begin
      sync1 <= {sclk, cs_n, hold_n, wp_n, bidir_data_line_in};
      sync2 <= sync1;
   end

   wire s_sclk = sync2[4];
   wire s_cs_n = sync2[3];
   wire s_hold = sync2[2];
   wire s_wp_n = sync2[1];
   wire s_din  = sync2[0];

   always @(posedge core_clk) begin
      if (!rst_n) begin
         sclk_d <= 1'b0;
         cs_d   <= 1'b1;
      end else begin
         sclk_d <= s_sclk;
         cs_d   <= s_cs_n;
      end
   end

   wire sclk_rise = s_sclk & ~sclk_d;
   wire sclk_fall = ~s_sclk & sclk_d;
   wire cs_fall   = ~s_cs_n & cs_d;
   wire cs_rise   = s_cs_n & ~cs_d;

   // ************************************************************
   // pause (hold) tracking
   // ************************************************************
   reg paused;

   // a change of the pause pin takes effect at once if the clock is
   // low, else waits for the next falling clock edge
   always @(posedge core_clk) begin
      if (!rst_n || s_cs_n) begin
         paused <= 1'b0;
      end else if (!s_hold && !paused &&
                   (!s_sclk || sclk_fall)) begin
         paused <= 1'b1;
      end else if (s_hold && paused &&
                   (!s_sclk || sclk_fall)) begin
         paused <= 1'b0;
      end
   end

   // serial clock edges are dropped while paused
   wire run   = ~s_cs_n & ~paused;
   wire srise = sclk_rise & run;
   wire sfall = sclk_fall & run;

   // ************************************************************
   // protection helpers
   // ************************************************************
   // true when a 24-bit address falls in the protected region
   function prot_hit;
      input [2:0]  size;
      input        side;
      input [23:0] addr;
      reg   [6:0]  blk;
      reg   [7:0]  span;
      begin
         blk  = addr[22:16];
         span = (size == 3'h0) ? 8'h00 :
                (size == 3'h7) ? 8'h80 : (8'h01 << size);
         if (size == 3'h7)
            prot_hit = 1'b1;
         else if (side)
            prot_hit = ({1'b0, blk} < span);
         else
            prot_hit = ({1'b0, blk} >= (8'h80 - span));
      end
   endfunction

   function is_write_op;
      input [7:0] op;
      begin
         is_write_op = (op == `SFSFE_OP_PP) || (op == `SFSFE_OP_SE) ||
                       (op == `SFSFE_OP_BE32) ||
                       (op == `SFSFE_OP_BE64) ||
                       (op == `SFSFE_OP_CE) || (op == `SFSFE_OP_WRSR);
      end
   endfunction

   // ************************************************************
   // power-up delay and busy timer
   // ************************************************************
   reg [15:0] puw_cnt;
   reg        puw_done;
   reg [15:0] busy_cnt;
   reg        busy;
   reg        start_busy;

   // the delay counter starts at reset release; write ops wait for it
   always @(posedge core_clk) begin
      if (!rst_n) begin
         puw_cnt  <= 16'h0000;
         puw_done <= 1'b0;
      end else if (!puw_done) begin
         puw_cnt  <= puw_cnt + 16'h0001;
         puw_done <= (puw_cnt >= PUW_CYCLES[15:0] - 16'h0001);
      end
   end

   // busy stands for a fixed internal cycle; no array here
   always @(posedge core_clk) begin
      if (!rst_n) begin
         busy     <= 1'b0;
         busy_cnt <= 16'h0000;
      end else if (start_busy) begin
         busy     <= 1'b1;
         busy_cnt <= BUSY_CYCLES[15:0];
      end else if (busy) begin
         busy_cnt <= busy_cnt - 16'h0001;
         busy     <= (busy_cnt != 16'h0001);
      end
   end

   // ************************************************************
   // serial shifter and instruction decode
   // ************************************************************
   reg [7:0]  shreg;
   reg [2:0]  bitn;
   reg [3:0]  bytes;
   reg [7:0]  opcode;
   reg [23:0] addr;
   reg [7:0]  wr_data;
   reg        wr_seen;
   reg        have_op;
   reg        write_latch;
   reg [2:0]  region_size;
   reg        region_side;
   reg        status_lock;
   reg        pdown;
   reg [7:0]  tx;
   reg        dual_out;

   // status word as read; reserved bit tied low
   wire [7:0] status_word = {status_lock, 1'b0, region_side,
                             region_size, write_latch, busy};

   wire [7:0] shnext = {shreg[6:0], s_din};
   wire       byte_done = srise & (bitn == 3'h7);
   wire       whole = (bitn == 3'h0);
   wire       lock_on = status_lock & ~s_wp_n;
   wire       may_write = write_latch & puw_done & ~busy & ~pdown;

   // frame sequencing: opcode, address, data; held across a pause
   always @(posedge core_clk) begin
      if (!rst_n || cs_fall) begin
         bitn    <= 3'h0;
         bytes   <= 4'h0;
         have_op <= 1'b0;
         wr_seen <= 1'b0;
         shreg   <= 8'h00;
         opcode  <= 8'h00;
         addr    <= 24'h000000;
         wr_data <= 8'h00;
      end else if (srise) begin
         shreg <= shnext;
         bitn  <= bitn + 3'h1;
         if (byte_done) begin
            if (bytes != 4'hf)
               bytes <= bytes + 4'h1;
            if (!have_op) begin
               opcode  <= shnext;
               have_op <= 1'b1;
            end else if (bytes < `SFSFE_ADDR_END) begin
               addr <= {addr[15:0], shnext};
            end else if (!wr_seen) begin
               wr_data <= shnext;
               wr_seen <= 1'b1;
            end
            if (have_op && opcode == `SFSFE_OP_WRSR && !wr_seen) begin
               wr_data <= shnext;
               wr_seen <= 1'b1;
            end
         end
      end
   end

   // end-of-frame commit, status word and power-down state
   always @(posedge core_clk) begin
      start_busy  <= 1'b0;
      prog_strobe <= 1'b0;
      if (!rst_n) begin
         write_latch <= 1'b0;
         region_size <= 3'h0;
         region_side <= 1'b0;
         status_lock <= 1'b0;
         pdown       <= 1'b0;
         prog_opcode <= 8'h00;
         prog_addr   <= 24'h000000;
      end else if (cs_rise && have_op && whole) begin
         // busy frames, and powered-down frames other than release, fall through untouched
         if (pdown) begin
            if (opcode == `SFSFE_OP_RPD)
               pdown <= 1'b0;
         end else if (busy) begin
            pdown <= pdown;
         end else if (opcode == `SFSFE_OP_WREN) begin
            if (puw_done)
               write_latch <= 1'b1;
         end else if (opcode == `SFSFE_OP_WRDI) begin
            write_latch <= 1'b0;
         end else if (opcode == `SFSFE_OP_PD) begin
            pdown <= 1'b1;
         end else if (is_write_op(opcode) && may_write) begin
            write_latch <= 1'b0;
            if (opcode == `SFSFE_OP_WRSR) begin
               if (!lock_on && wr_seen) begin
                  region_size <= wr_data[`SFSFE_S_SZ_HI:`SFSFE_S_SZ_LO];
                  region_side <= wr_data[`SFSFE_S_SIDE];
                  status_lock <= wr_data[`SFSFE_S_LOCK];
                  start_busy  <= 1'b1;
               end
            end else if (opcode == `SFSFE_OP_CE ?
                         (region_size == 3'h0) :
                         !prot_hit(region_size, region_side,
                                   addr)) begin
               start_busy  <= 1'b1;
               prog_strobe <= 1'b1;
               prog_opcode <= opcode;
               prog_addr   <= addr;
            end
         end
      end
   end

   // ************************************************************
   // output driver
   // ************************************************************
   // read data is not modelled here: data reads return zeros
   wire op_ok  = ~pdown & (~busy | (opcode == `SFSFE_OP_RDSR));
   wire is_rd  = have_op & op_ok & ((opcode == `SFSFE_OP_RDSR) ||
                 (bytes >= `SFSFE_ADDR_END &&
                  (opcode == `SFSFE_OP_READ)) ||
                 (bytes >= `SFSFE_DUMMY_END &&
                  (opcode == `SFSFE_OP_FREAD ||
                   opcode == `SFSFE_OP_DREAD)));

   // bits change only on falling serial clock
   always @(posedge core_clk) begin
      if (!rst_n || s_cs_n) begin
         tx       <= 8'h00;
         dual_out <= 1'b0;
         dout     <= 1'b0;
         bidir_data_line_out <= 1'b0;
      end else if (sfall && is_rd) begin
         dual_out <= (opcode == `SFSFE_OP_DREAD);
         if (opcode == `SFSFE_OP_DREAD) begin
            if (bitn[0] == 1'b0)
               tx <= 8'h00;
            dout <= tx[7];
            bidir_data_line_out <= tx[6];
            tx <= {tx[5:0], 2'b00};
         end else begin
            if (bitn == 3'h0 && opcode == `SFSFE_OP_RDSR)
               tx <= {status_word[6:0], 1'b0};
            else
               tx <= {tx[6:0], 1'b0};
            dout <= (bitn == 3'h0 && opcode == `SFSFE_OP_RDSR) ?
                    status_word[7] : tx[7];
         end
      end
   end

   // output enables follow select, pause and read phase
   always @(posedge core_clk) begin
      if (!rst_n) begin
         dout_oe            <= 1'b0;
         bidir_data_line_oe <= 1'b0;
         status_view        <= `SFSFE_STATUS_RST;
      end else begin
         status_view <= status_word;
         dout_oe <= run & is_rd;
         bidir_data_line_oe <= run & is_rd & dual_out;
      end
   end

endmodule

// [verification/sfsfe_chk.sv]
// checker for the serial flash front end, ports of sfsfe_top only
// assumes a bind from the bench top; one clock domain, sync reset
`timescale 1ns/1ps
module sfsfe_chk (
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        sclk,
   input wire logic        cs_n,
   input wire logic        hold_n,
   input wire logic        wp_n,
   input wire logic        bidir_data_line_in,
   input wire logic        bidir_data_line_out,
   input wire logic        bidir_data_line_oe,
   input wire logic        dout,
   input wire logic        dout_oe,
   input wire logic        prog_strobe,
   input wire logic [7:0]  prog_opcode,
   input wire logic [23:0] prog_addr,
   input wire logic [7:0]  status_view
);
   localparam int BUSY_MAX = 400;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ************************************************************
   // pause and accept sequences
   // ************************************************************
   // six cycles cover the pin synchroniser delay
   sequence paused_s;
      (!hold_n && !cs_n && !sclk)[*6];
   endsequence
   sequence accept_s;
      prog_strobe ##0 $past(status_view[1]);
   endsequence
   rsvd_zero_a: assert property (status_view[6] == 1'b0)
      else $error("reserved status bit set");
   paused_quiet_a: assert property (
      paused_s |-> !dout_oe && !bidir_data_line_oe)
      else $error("output driven while paused");
   pair_drive_a: assert property (
      bidir_data_line_oe |-> dout_oe)
      else $error("dual drive without serial out");
   strobe_latch_a: assert property (prog_strobe |-> accept_s)
      else $error("write accepted without latch");
   strobe_busy_a: assert property (
      prog_strobe |-> ##[0:2] status_view[0])
      else $error("busy not raised");
   strobe_clear_a: assert property (
      prog_strobe |-> ##[0:3] !status_view[1])
      else $error("latch not cleared");
   busy_end_a: assert property (
      $rose(status_view[0]) |-> ##[1:BUSY_MAX] !status_view[0])
      else $error("busy never ends");
   commit_edge_a: assert property (
      !$stable(status_view[7:1]) |-> cs_n)
      else $error("status changed inside a frame");
endmodule

// [verification/sfsfe_host.sv]
// spi host model driving clock, select, pause and data-in
// assumes a 40 ns core clock; one serial period is 8 core cycles
`timescale 1ns/1ps
module sfsfe_host (
   input  wire logic core_clk,
   input  wire logic dout,
   input  wire logic dout_oe,
   output logic      sclk,
   output logic      cs_n,
   output logic      hold_n,
   output logic      host_di
);
   logic idle_hi;
   logic leak;
   initial begin
      {sclk, cs_n, hold_n, host_di, idle_hi} = 5'b01100;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // ************************************************************
   // one frame, tx left aligned, msb first
   // ************************************************************
   task automatic xfer(input logic [63:0] tx, input int n,
                       input int hold_at, output logic [63:0] rx);
      rx = '0;
      leak = 0;
      sclk = idle_hi; // mode 0 or 3 idle level
      cs_n = 0;
      wt(4);
      for (int i = 0; i < n; i++) begin
         sclk = 0;
         host_di = tx[63-i];
         wt(4);
         if (i == hold_at) begin
            // pause with clock low; held select
            hold_n = 0;
            wt(6);
            repeat (12) begin
               wt(1);
               sclk = ~sclk;
               host_di = ~host_di;
               leak |= dout_oe;
            end
            hold_n = 1; // clock low, so pause ends here
            wt(4);
         end
         sclk = 1;
         wt(4);
         rx = {rx[62:0], dout_oe ? dout : ~dout}; // off line reads wrong
      end
      sclk = idle_hi;
      wt(4);
      cs_n = 1;
      host_di = ~host_di; // released line must not hold its value
      wt(8);
   endtask
endmodule

// [verification/sfsfe_tb_top.sv]
// bench top for the serial flash front end
// assumes a short power-up count and a shorter busy count set at the instance
`timescale 1ns/1ps
module sfsfe_tb_top;
   logic        core_clk = 0;
   logic        rst_n = 0;
   logic        wp_n = 1;
   logic        sclk, cs_n, hold_n, host_di, line;
   logic        bd_out, bd_oe, dout, dout_oe, prog_strobe;
   logic [7:0]  prog_opcode, status_view;
   logic [23:0] prog_addr;
   logic [63:0] rx;
   int          bad_count, tests_run, strobes, dual_seen;
   initial forever #20 core_clk = ~core_clk;
   assign line = bd_oe ? bd_out : host_di;
   sfsfe_top #(.PUW_CYCLES(150), .BUSY_CYCLES(120)) u_sfsfe_top (
      .core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
      .hold_n(hold_n), .wp_n(wp_n), .bidir_data_line_in(line),
      .bidir_data_line_out(bd_out), .bidir_data_line_oe(bd_oe),
      .dout(dout), .dout_oe(dout_oe), .prog_strobe(prog_strobe),
      .prog_opcode(prog_opcode), .prog_addr(prog_addr),
      .status_view(status_view));
   sfsfe_host u_sfsfe_host (.core_clk(core_clk), .dout(dout),
      .dout_oe(dout_oe), .sclk(sclk), .cs_n(cs_n), .hold_n(hold_n),
      .host_di(host_di));
   // count accepted writes; dual drive must carry zero array data
   always @(posedge core_clk) begin
      if (prog_strobe === 1'b1) strobes++;
      if (bd_oe === 1'b1)
         dual_seen = (bd_out === 1'b0 && dual_seen != 2) ? 1 : 2;
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic x(input logic [63:0] tx, input int n);
      u_sfsfe_host.xfer(tx, n, -1, rx);
   endtask
   task automatic wr(input logic [63:0] tx, input int n);
      x({8'h06, 56'h0}, 8);
      x(tx, n);
      u_sfsfe_host.wt(150); // outlast the busy time
   endtask
   task automatic summarize;
      $display("tests_run %0d bad_count %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #2000000;
      bad_count++;
      summarize;
   end
   initial begin
      repeat (6) @(negedge core_clk);
      rst_n = 1;
      chk(status_view, 8'h00);
      x({8'h06, 56'h0}, 8);
      chk(status_view[1], 0);
      u_sfsfe_host.wt(150);
      x({8'h06, 56'h0}, 8);
      chk(status_view[1], 1);
      x({8'h05, 56'h0}, 16);
      chk(rx[7:0], 8'h02);
      x({8'h04, 56'h0}, 8);
      chk(status_view[1], 0);
      x({8'h02, 24'h000100, 8'h5a, 24'h0}, 40);
      chk(strobes, 0);
      u_sfsfe_host.idle_hi = 1;
      x({8'h06, 56'h0}, 8);
      chk(status_view[1], 1);
      u_sfsfe_host.idle_hi = 0;
      x({8'h02, 24'h000100, 8'h5a, 24'h0}, 40);
      chk({strobes[1:0], prog_opcode, prog_addr},
          {2'd1, 32'h02000100});
      chk(status_view[1:0], 2'b01);
      u_sfsfe_host.wt(150);
      chk(status_view[0], 0);
      $display("test done: latch and program");
      wr({8'h01, 8'h9c, 48'h0}, 16);
      chk(status_view, 8'h9c);
      wp_n = 0;
      wr({8'h01, 8'h00, 48'h0}, 16);
      chk(status_view & 8'hfc, 8'h9c);
      wr({8'h02, 24'h000000, 8'h11, 24'h0}, 40);
      chk(strobes, 1);
      wp_n = 1;
      wr({8'h01, 8'h24, 48'h0}, 16);
      chk(status_view, 8'h24);
      wr({8'h02, 24'h7f0000, 8'h11, 24'h0}, 40);
      chk(strobes, 2);
      wr({8'h02, 24'h010000, 8'h11, 24'h0}, 40);
      wr({8'h20, 24'h7f1000, 32'h0}, 31);
      chk(strobes, 2);
      $display("test done: protection");
      u_sfsfe_host.xfer({8'h05, 56'h0}, 16, 11, rx);
      chk(rx[7:0] & 8'hfd, 8'h24);
      chk(u_sfsfe_host.leak, 0);
      chk(dual_seen, 0);
      x({8'h3b, 40'h0, 16'h0}, 48);
      chk({dual_seen[1:0], rx[7:0]}, 10'h100);
      $display("test done: pause and dual read");
      x({8'h04, 56'h0}, 8);
      x({8'hb9, 56'h0}, 8);
      x({8'h06, 56'h0}, 8);
      chk(status_view[1], 0);
      x({8'hab, 56'h0}, 8);
      x({8'h06, 56'h0}, 8);
      chk(status_view[1], 1);
      $display("test done: power-down");
      summarize;
   end
endmodule
bind sfsfe_top sfsfe_chk u_sfsfe_chk (.core_clk(core_clk), .rst_n(rst_n),
   .sclk(sclk), .cs_n(cs_n), .hold_n(hold_n), .wp_n(wp_n),
   .bidir_data_line_in(bidir_data_line_in),
   .bidir_data_line_out(bidir_data_line_out),
   .bidir_data_line_oe(bidir_data_line_oe), .dout(dout),
   .dout_oe(dout_oe), .prog_strobe(prog_strobe),
   .prog_opcode(prog_opcode), .prog_addr(prog_addr),
   .status_view(status_view));
